// ---- mfpc_pkg.sv ----
// shared constants and types for the general-purpose pin 0 control block
`default_nettype none
package mfpc_pkg;

    localparam logic [7:0] PIN0_ROLE_CONTROL_OFFSET = 8'h88;
    localparam logic [2:0] OWNER_FUNCTION = 3'h0;
    localparam logic [7:0] PIN0_ROLE_CONTROL_RESET = 8'h80;

    localparam int ROLE_HI_BIT = 7;
    localparam int ROLE_LO_BIT = 6;
    localparam int RSVD_HI_BIT = 5;
    localparam int IRQ_EN_BIT = 4;
    localparam int CHANGE_FLAG_BIT = 3;
    localparam int RSVD_LO_BIT = 2;
    localparam int OUT_VALUE_BIT = 1;
    localparam int IN_VALUE_BIT = 0;

    localparam int SYNC_STAGES = 2;

    // encodings follow declaration order: 00, 01, 10, 11
    typedef enum logic [1:0] {
        ROLE_ACTIVITY,
        ROLE_VIDEO_STATUS,
        ROLE_INPUT,
        ROLE_OUTPUT
    } mfpc_role_t;

    localparam mfpc_role_t ROLE_RESET = mfpc_role_t'(PIN0_ROLE_CONTROL_RESET[7:6]);
    localparam logic IRQ_EN_RESET = PIN0_ROLE_CONTROL_RESET[4];
    localparam logic CHANGE_FLAG_RESET = PIN0_ROLE_CONTROL_RESET[3];
    localparam logic OUT_VALUE_RESET = PIN0_ROLE_CONTROL_RESET[1];
    localparam logic IN_VALUE_RESET = PIN0_ROLE_CONTROL_RESET[0];

    // one configuration-space access cycle
    typedef struct packed {
        logic write;
        logic read;
        logic [2:0] func;
        logic [7:0] addr;
        logic [7:0] data;
    } mfpc_cfg_req_t;

    // terminal drive, two-signal form
    typedef struct packed {
        logic level;
        logic enable;
    } mfpc_pin_drive_t;

endpackage
`default_nettype wire

// ---- mfpc_sync.sv ----
// multi-stage level synchroniser for the terminal input
`timescale 1ns/1ps
`default_nettype none
module mfpc_sync #(
    parameter int STAGES = mfpc_pkg::SYNC_STAGES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic asyncIn,
    output logic syncOut
);

    logic [STAGES-1:0] chain_q;

    // only the last stage is read outside; earlier stages feed the next one alone
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            chain_q <= '0;
        end else if (ce) begin
            chain_q <= {chain_q[STAGES-2:0], asyncIn};
        end
    end

    assign syncOut = chain_q[STAGES-1];

endmodule
`default_nettype wire

// ---- mfpc_pin0_ctrl.sv ----
// general-purpose pin 0 role control register and terminal logic
// Behaviour
// - bits 7-6 pick the terminal role: 00 activity, 01 video status, 10 input, 11 output.
// - after reset the register reads 80h: input role, enable, flag and output bit all clear.
// - in role 00 the terminal is driven high while socket 0 is carrying out accesses.
// - in role 01 the terminal shows whether the video port output drivers are enabled.
// - the video-enabled condition is the top bit of the multimedia control register.
// - bits 5 and 2 always read zero and writes to them are ignored.
// - in input role the change flag in bit 3 is set whenever the captured input toggles.
// - the change flag stays set until software writes a one to it, which clears it unless an input toggle comes in the same cycle.
// - with bit 4 set, a set change flag raises the socket A card status change interrupt.
// - in output role the terminal is driven with bit 1, and writes to bit 1 update it.
// - in input and output roles bit 0 returns the level present on the terminal.
`timescale 1ns/1ps
`default_nettype none
module mfpc_pin0_ctrl #(
    parameter int SYNC_DEPTH = mfpc_pkg::SYNC_STAGES
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic ce,
    input wire mfpc_pkg::mfpc_cfg_req_t cfgReq,
    output logic [7:0] cfgRdData,
    output logic cfgRdValid,
    input wire logic socket0Active,
    input wire logic videoOutputEnable,
    input wire logic pinIn,
    output logic pinOut,
    output logic pinOe,
    output logic cardStatusChangeIrq
);

    // register fields
    mfpc_pkg::mfpc_role_t pinRoleField_q;
    mfpc_pkg::mfpc_role_t pinRoleField_d;
    logic changeIrqEnable_q;
    logic changeIrqEnable_d;
    logic inputChangeFlag_q;
    logic inputChangeFlag_d;
    logic outputValueBit_q;
    logic outputValueBit_d;
    logic inputValueBit_q;
    logic inputValueBit_d;

    // output flops
    logic [7:0] cfgRdData_q;
    logic [7:0] cfgRdData_d;
    logic cfgRdValid_q;
    mfpc_pkg::mfpc_pin_drive_t pinDrive_q;
    mfpc_pkg::mfpc_pin_drive_t pinDrive_d;
    logic irq_q;
    logic irq_d;

    // decode
    logic regHit;
    logic wrHit;
    logic rdHit;
    logic syncLevel;
    logic inputRole;
    logic sampleRole;
    logic changeEvent;
    logic clearFlag;
    logic [7:0] regView;
    mfpc_pkg::mfpc_role_t wrRole;

    mfpc_sync #(
        .STAGES(SYNC_DEPTH)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst(rst),
        .ce(ce),
        .asyncIn(pinIn),
        .syncOut(syncLevel)
    );

    // function 1 aliases of the offset are not decoded on purpose; reads there are answered with 00h
    assign regHit = (cfgReq.func == mfpc_pkg::OWNER_FUNCTION)
        && (cfgReq.addr == mfpc_pkg::PIN0_ROLE_CONTROL_OFFSET);
    assign wrHit = cfgReq.write && regHit;
    assign rdHit = cfgReq.read && regHit;
    assign wrRole = mfpc_pkg::mfpc_role_t'(
        cfgReq.data[mfpc_pkg::ROLE_HI_BIT:mfpc_pkg::ROLE_LO_BIT]);

    assign inputRole = (pinRoleField_q == mfpc_pkg::ROLE_INPUT);
    assign sampleRole = inputRole || (pinRoleField_q == mfpc_pkg::ROLE_OUTPUT);

    // compare against the held bit, so a toggle is seen once per edge of the level
    assign changeEvent = inputRole && (syncLevel != inputValueBit_q);
    assign clearFlag = wrHit && cfgReq.data[mfpc_pkg::CHANGE_FLAG_BIT];

    // reserved positions are constant zero
    assign regView = {
        pinRoleField_q,
        1'b0,
        changeIrqEnable_q,
        inputChangeFlag_q,
        1'b0,
        outputValueBit_q,
        inputValueBit_q
    };

    assign pinRoleField_d = wrHit ? wrRole : pinRoleField_q;
    assign changeIrqEnable_d = wrHit ? cfgReq.data[mfpc_pkg::IRQ_EN_BIT] : changeIrqEnable_q;
    assign outputValueBit_d = wrHit ? cfgReq.data[mfpc_pkg::OUT_VALUE_BIT] : outputValueBit_q;

    // a toggle in the clearing cycle keeps the flag set
    assign inputChangeFlag_d = changeEvent ? 1'b1
        : (clearFlag ? 1'b0 : inputChangeFlag_q);

    // bit 0 is written by hardware only; in other roles it keeps its last sample
    assign inputValueBit_d = sampleRole ? syncLevel : inputValueBit_q;

    assign cfgRdData_d = rdHit ? regView : 8'h00;

    // level interrupt, removed when either the enable or the flag drops
    assign irq_d = changeIrqEnable_q && inputChangeFlag_q;

    always_comb begin
        pinDrive_d = '{level: 1'b0, enable: 1'b0};
        case (pinRoleField_q)
            mfpc_pkg::ROLE_ACTIVITY: begin
                pinDrive_d = '{level: socket0Active, enable: 1'b1};
            end
            mfpc_pkg::ROLE_VIDEO_STATUS: begin
                // neighbouring register bit 7; when clear the video pins float
                pinDrive_d = '{level: videoOutputEnable, enable: 1'b1};
            end
            mfpc_pkg::ROLE_INPUT: begin
                pinDrive_d = '{level: 1'b0, enable: 1'b0};
            end
            mfpc_pkg::ROLE_OUTPUT: begin
                pinDrive_d = '{level: outputValueBit_q, enable: 1'b1};
            end
            default: begin
                pinDrive_d = '{level: 1'b0, enable: 1'b0};
            end
        endcase
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pinRoleField_q <= mfpc_pkg::ROLE_RESET;
            changeIrqEnable_q <= mfpc_pkg::IRQ_EN_RESET;
            inputChangeFlag_q <= mfpc_pkg::CHANGE_FLAG_RESET;
            outputValueBit_q <= mfpc_pkg::OUT_VALUE_RESET;
            inputValueBit_q <= mfpc_pkg::IN_VALUE_RESET;
        end else if (ce) begin
            pinRoleField_q <= pinRoleField_d;
            changeIrqEnable_q <= changeIrqEnable_d;
            inputChangeFlag_q <= inputChangeFlag_d;
            outputValueBit_q <= outputValueBit_d;
            inputValueBit_q <= inputValueBit_d;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfgRdData_q <= 8'h00;
            cfgRdValid_q <= 1'b0;
            pinDrive_q <= '{level: 1'b0, enable: 1'b0};
            irq_q <= 1'b0;
        end else if (ce) begin
            cfgRdData_q <= cfgRdData_d;
            cfgRdValid_q <= cfgReq.read;
            pinDrive_q <= pinDrive_d;
            irq_q <= irq_d;
        end
    end

    assign cfgRdData = cfgRdData_q;
    assign cfgRdValid = cfgRdValid_q;
    assign pinOut = pinDrive_q.level;
    assign pinOe = pinDrive_q.enable;
    assign cardStatusChangeIrq = irq_q;

    AST_RESET_VALUE: assert property (@(posedge sys_clk)
        $past(rst) && !rst |-> regView == mfpc_pkg::PIN0_ROLE_CONTROL_RESET)
        else $error("register did not read 80h after reset");

    AST_INPUT_FLOATS: assert property (@(posedge sys_clk) disable iff (rst)
        ce && pinRoleField_q == mfpc_pkg::ROLE_INPUT |=> !pinOe)
        else $error("terminal driven in input role");

    AST_ACTIVITY_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && pinRoleField_q == mfpc_pkg::ROLE_ACTIVITY
        |=> pinOe && pinOut == $past(socket0Active))
        else $error("activity role does not follow socket 0 activity");

    AST_VIDEO_STATUS: assert property (@(posedge sys_clk) disable iff (rst)
        ce && pinRoleField_q == mfpc_pkg::ROLE_VIDEO_STATUS
        |=> pinOe && pinOut == $past(videoOutputEnable))
        else $error("video status role does not follow the video output enable");

    AST_OUTPUT_DRIVE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && wrHit && wrRole == mfpc_pkg::ROLE_OUTPUT ##1 ce
        |=> pinOe && pinOut == $past(cfgReq.data[mfpc_pkg::OUT_VALUE_BIT], 2))
        else $error("output role does not drive the written output bit");

    AST_RESERVED_ZERO: assert property (@(posedge sys_clk) disable iff (rst)
        cfgRdValid |-> !cfgRdData[mfpc_pkg::RSVD_HI_BIT] && !cfgRdData[mfpc_pkg::RSVD_LO_BIT])
        else $error("reserved bit read back as one");

    AST_CHANGE_SETS_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        ce && inputRole && $changed(syncLevel) && syncLevel != inputValueBit_q
        |=> inputChangeFlag_q)
        else $error("input toggle did not set the change flag");

    AST_FLAG_STICKY: assert property (@(posedge sys_clk) disable iff (rst)
        inputChangeFlag_q && !(ce && clearFlag) |=> inputChangeFlag_q)
        else $error("change flag dropped without a write of one");

    AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
        ce && clearFlag && !changeEvent |=> !inputChangeFlag_q)
        else $error("write of one did not clear the change flag");

    AST_NO_SOFT_SET: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !inputChangeFlag_q && !changeEvent |=> !inputChangeFlag_q)
        else $error("change flag set without an input toggle");

    AST_IRQ_RAISED: assert property (@(posedge sys_clk) disable iff (rst)
        ce && changeEvent && changeIrqEnable_q ##1 ce && changeIrqEnable_q
        |=> cardStatusChangeIrq)
        else $error("enabled change flag did not raise the interrupt");

    AST_IRQ_CAUSED: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cardStatusChangeIrq) |-> $past(changeIrqEnable_q) && $past(inputChangeFlag_q))
        else $error("interrupt raised without enable and flag");

    AST_INPUT_SAMPLE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && sampleRole ##1 ce && sampleRole && $stable(pinIn)[*1] ##1 ce && sampleRole
        |=> inputValueBit_q == $past(pinIn, 3))
        else $error("input bit does not track the terminal level");

    AST_READ_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
        ce && cfgReq.read && !regHit |=> cfgRdValid && cfgRdData == 8'h00)
        else $error("read outside function 0 offset 88h returned data");

    AST_SET_WINS: assert property (@(posedge sys_clk) disable iff (rst)
        ce && changeEvent |=> inputChangeFlag_q)
        else $error("change flag lost a toggle that met a clearing write");

    AST_FLAG_NEEDS_INPUT_ROLE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !inputRole && !inputChangeFlag_q |=> !inputChangeFlag_q)
        else $error("change flag set outside the input role");

    AST_ROLE_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && wrHit |=> pinRoleField_q == $past(wrRole))
        else $error("role field did not take the written value");

    AST_ROLE_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !wrHit |=> $stable(pinRoleField_q))
        else $error("role field changed without a write");

    AST_DRIVEN_ROLES: assert property (@(posedge sys_clk) disable iff (rst)
        ce && pinRoleField_q != mfpc_pkg::ROLE_INPUT |=> pinOe)
        else $error("terminal not driven outside the input role");

    AST_ENABLE_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && wrHit |=> changeIrqEnable_q == $past(cfgReq.data[mfpc_pkg::IRQ_EN_BIT]))
        else $error("interrupt enable did not take the written value");

    AST_OUT_BIT_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && wrHit |=> outputValueBit_q == $past(cfgReq.data[mfpc_pkg::OUT_VALUE_BIT]))
        else $error("output bit did not take the written value");

    AST_MISSED_WRITE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && cfgReq.write && !regHit
        |=> $stable(pinRoleField_q) && $stable(changeIrqEnable_q) && $stable(outputValueBit_q))
        else $error("write outside function 0 offset 88h changed the register");

    AST_READ_DATA: assert property (@(posedge sys_clk) disable iff (rst)
        ce && rdHit |=> cfgRdValid && cfgRdData == $past(regView))
        else $error("read did not return the register contents");

    AST_READ_IDLE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !cfgReq.read |=> !cfgRdValid && cfgRdData == 8'h00)
        else $error("read answer shown without a read");

    AST_HELD_IN_BIT: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !sampleRole |=> $stable(inputValueBit_q))
        else $error("input bit moved outside the input and output roles");

    AST_IRQ_FROM_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        ce && changeIrqEnable_q && inputChangeFlag_q |=> cardStatusChangeIrq)
        else $error("enabled change flag is not shown as an interrupt");

    AST_IRQ_NEEDS_ENABLE: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !changeIrqEnable_q |=> !cardStatusChangeIrq)
        else $error("interrupt raised while disabled");

    AST_IRQ_NEEDS_FLAG: assert property (@(posedge sys_clk) disable iff (rst)
        ce && !inputChangeFlag_q |=> !cardStatusChangeIrq)
        else $error("interrupt raised with the change flag clear");

    AST_CLEAR_DROPS_IRQ: assert property (@(posedge sys_clk) disable iff (rst)
        ce && clearFlag && !changeEvent ##1 ce |=> !cardStatusChangeIrq)
        else $error("interrupt stayed up after the change flag was cleared");

    AST_RESET_DRIVE: assert property (@(posedge sys_clk)
        $past(rst) && !rst |-> !pinOe && !cardStatusChangeIrq && !cfgRdValid)
        else $error("outputs not at their reset levels after reset");

endmodule
`default_nettype wire

// ---- mfpc_pin_load.sv ----
// far-side model of terminal 0: a driven external source plus the device drive
`timescale 1ns/1ps
`default_nettype none
module mfpc_pin_load (
    input wire logic pinOut,
    input wire logic pinOe,
    input wire logic extLevel,
    output logic pinIn
);
    // device drive wins; the outside source only shows while the device is tristated
    assign pinIn = pinOe ? pinOut : extLevel;
endmodule
`default_nettype wire

// ---- test_multifunction_pin0_control.sv ----
// self-checking bench for the pin 0 role control block
`timescale 1ns/1ps
`default_nettype none
module test_multifunction_pin0_control;
    typedef struct {
        logic [7:0] data;
        logic [7:0] rdExp;
        logic oeExp;
    } mfpc_row_t;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic ce = 1'b1;
    mfpc_pkg::mfpc_cfg_req_t cfgReq = '0;
    logic [7:0] cfgRdData;
    logic cfgRdValid;
    logic socket0Active = 1'b0;
    logic videoOutputEnable = 1'b0;
    logic pinIn;
    logic pinOut;
    logic pinOe;
    logic cardStatusChangeIrq;
    logic extLevel = 1'b0;
    int error_cnt = 0;
    int n_tests = 0;
    int cycles = 0;
    mfpc_row_t rows [5];

    always #4 sys_clk = ~sys_clk;

    mfpc_pin0_ctrl #(.SYNC_DEPTH(2)) mfpc_pin0_ctrl_inst (
        .sys_clk(sys_clk), .rst(rst), .ce(ce), .cfgReq(cfgReq), .cfgRdData(cfgRdData),
        .cfgRdValid(cfgRdValid), .socket0Active(socket0Active),
        .videoOutputEnable(videoOutputEnable), .pinIn(pinIn), .pinOut(pinOut),
        .pinOe(pinOe), .cardStatusChangeIrq(cardStatusChangeIrq)
    );

    mfpc_pin_load mfpc_pin_load_inst (
        .pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel), .pinIn(pinIn)
    );

    task automatic final_report();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // a hang in a bounded wait ends the run as a failure
    always @(posedge sys_clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            error_cnt = error_cnt + 1;
            final_report();
        end
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests = n_tests + 1;
        if (seen !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // an idle edge closes every access, so the next one never rewrites the strobe in one step
    task automatic wr(input logic [2:0] f, input logic [7:0] a, input logic [7:0] d);
        cfgReq = {1'b1, 1'b0, f, a, d};
        cyc(1);
        cfgReq = '0;
        cyc(1);
    endtask

    // read answer is registered, so it stands in the cycle right after the taking edge
    task automatic rd(input logic [2:0] f, input logic [7:0] a, input logic [7:0] exp);
        cfgReq = {1'b0, 1'b1, f, a, 8'h00};
        cyc(1);
        cfgReq = '0;
        chk({7'h00, cfgRdValid}, 8'h01);
        chk(cfgRdData, exp);
        cyc(1);
    endtask

    initial begin
        rows[0] = '{8'hff, 8'hd3, 1'b1};
        rows[1] = '{8'hc0, 8'hc0, 1'b1};
        rows[2] = '{8'h24, 8'h00, 1'b1};
        rows[3] = '{8'h40, 8'h40, 1'b1};
        rows[4] = '{8'h92, 8'h92, 1'b0};
        cyc(10);
        rst = 1'b0;
        chk({7'h00, pinOe}, 8'h00);
        rd(3'h0, 8'h88, 8'h80);
        foreach (rows[i]) begin
            wr(3'h0, 8'h88, rows[i].data);
            cyc(5);
            rd(3'h0, 8'h88, rows[i].rdExp);
            chk({7'h00, pinOe}, {7'h00, rows[i].oeExp});
        end
        // only function 0 at 88h reaches the register
        wr(3'h1, 8'h88, 8'hc0);
        wr(3'h0, 8'h89, 8'hc0);
        rd(3'h1, 8'h88, 8'h00);
        rd(3'h0, 8'h89, 8'h00);
        rd(3'h0, 8'h88, 8'h92);
        // a held clock enable drops the access
        ce = 1'b0;
        wr(3'h0, 8'h88, 8'hc0);
        ce = 1'b1;
        rd(3'h0, 8'h88, 8'h92);
        extLevel = 1'b1;
        cyc(5);
        rd(3'h0, 8'h88, 8'h9b);
        chk({7'h00, cardStatusChangeIrq}, 8'h01);
        wr(3'h0, 8'h88, 8'h92);
        rd(3'h0, 8'h88, 8'h9b);
        wr(3'h0, 8'h88, 8'h9a);
        rd(3'h0, 8'h88, 8'h93);
        chk({7'h00, cardStatusChangeIrq}, 8'h00);
        // short low glitch must still leave the flag behind
        extLevel = 1'b0;
        cyc(4);
        extLevel = 1'b1;
        cyc(5);
        rd(3'h0, 8'h88, 8'h9b);
        wr(3'h0, 8'h88, 8'hc2);
        cyc(2);
        chk({6'h00, pinOe, pinOut}, 8'h03);
        wr(3'h0, 8'h88, 8'hc0);
        cyc(2);
        chk({6'h00, pinOe, pinOut}, 8'h02);
        wr(3'h0, 8'h88, 8'h00);
        socket0Active = 1'b1;
        cyc(2);
        chk({6'h00, pinOe, pinOut}, 8'h03);
        socket0Active = 1'b0;
        cyc(2);
        chk({6'h00, pinOe, pinOut}, 8'h02);
        wr(3'h0, 8'h88, 8'h40);
        videoOutputEnable = 1'b1;
        cyc(2);
        chk({6'h00, pinOe, pinOut}, 8'h03);
        videoOutputEnable = 1'b0;
        cyc(2);
        chk({6'h00, pinOe, pinOut}, 8'h02);
        // second reset in mid-run brings the register back
        rst = 1'b1;
        cyc(2);
        rst = 1'b0;
        rd(3'h0, 8'h88, 8'h80);
        // the pin stood high through reset, so its first capture is a toggle
        cyc(3);
        rd(3'h0, 8'h88, 8'h89);
        final_report();
    end
endmodule
`default_nettype wire
